/* obcd_cfg_if.sv */
// Purpose: carries held option bytes to the decoder and decoded fields back
// Assumes: single clock domain
// Notes:   decoder outputs are flip-flops
`timescale 1ns/100ps
`default_nettype none
interface obcd_cfg_if;
    logic [7:0] ropByte;
    logic [7:0] bootByte;
    logic [7:0] dataByte;
    logic [7:0] wdgByte;
    logic       held;
    logic       readoutProtect;
    logic [6:0] bootPages;
    logic       bootVectorsOnly;
    logic       bootEnable;
    logic       bootWriteProtect;
    modport holder  (output ropByte, bootByte, dataByte, wdgByte, held,
                     input readoutProtect, bootPages, bootVectorsOnly, bootEnable, bootWriteProtect);
    modport decoder (input ropByte, bootByte, dataByte, wdgByte, held,
                     output readoutProtect, bootPages, bootVectorsOnly, bootEnable, bootWriteProtect);
endinterface
`default_nettype wire

/* obcd_config_decoder.sv */
// Purpose: option byte store, programming path and held configuration
// Assumes: write strobe comes from debug-link logic on mclk; mode pin is asynchronous
// Notes:   programmed bytes take effect only after the next reset
`timescale 1ns/100ps
`default_nettype none
`include "obcd_opt_map.svh"

// What this block does
// - option writes only in programming mode via link
// - protection byte 0xAA enables readout protection
// - size 0 none; 1-2 vectors only
// - size 3: pages 0-1 vectors, page 2 protected
// - size 0x7F protects pages 0-126, scaling between
// - boot size top bit forced to zero
module obcd_config_decoder (
    // clock and reset
    input  wire logic             mclk,
    input  wire logic             rst_n,
    // programming link side
    input  wire logic             icpModePin,
    input  wire logic             progWrite,
    input  wire logic             progRead,
    input  wire obcd_pkg::obcd_addr_type progAddr,
    input  wire obcd_pkg::obcd_byte_type progWrData,
    output var  obcd_pkg::obcd_byte_type progRdData,
    output var  logic             progAck,
    output var  logic             progReject,
    // decoded configuration
    output var  logic             configValid,
    output var  logic             readoutProtectEn,
    output var  logic             bootAreaEnable,
    output var  logic             bootVectorsOnly,
    output var  logic             bootWriteProtect,
    output var  logic [6:0]       bootAreaPages,
    output var  obcd_pkg::obcd_byte_type dataAreaSize,
    output var  logic             watchdogHaltOption,
    output var  logic             watchdogHwStartOption
);
    import obcd_pkg::*;

    obcd_byte_type optStore [`OBCD_NUM_BYTES] = '{default: `OBCD_FACTORY_VAL};
    obcd_byte_type ropHeld_reg;
    obcd_byte_type bootHeld_reg;
    obcd_byte_type dataHeld_reg;
    obcd_byte_type wdgHeld_reg;
    obcd_load_type loadState_reg;
    obcd_load_type loadState_next;
    logic          icpMeta_reg;
    logic          icpSync_reg;
    logic          writeOk;
    logic [3:0]    wrIdx;
    obcd_cfg_if    cfg ();

    // byte positions that hold an option; the gaps are unmapped
    function automatic logic isOption(input obcd_addr_type a);
        if (a == `OBCD_ADDR_ROP) begin
            return 1'b1;
        end else if (a == `OBCD_ADDR_BOOT) begin
            return 1'b1;
        end else if (a == `OBCD_ADDR_DATA) begin
            return 1'b1;
        end else if (a == `OBCD_ADDR_RSVD) begin
            return 1'b1;
        end else if (a == `OBCD_ADDR_WDG) begin
            return 1'b1;
        end else begin
            return 1'b0;
        end
    endfunction

    function automatic logic [3:0] byteIndex(input obcd_addr_type a);
        obcd_addr_type d;
        d = a - `OBCD_ADDR_BASE;
        return d[3:0];
    endfunction

    // mode pin is asynchronous, two flops before use
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            icpMeta_reg <= 1'b0;
            icpSync_reg <= 1'b0;
        end else begin
            icpMeta_reg <= icpModePin;
            icpSync_reg <= icpMeta_reg;
        end
    end

    // reserved byte must stay zero, so anything else is refused
    assign wrIdx   = byteIndex(progAddr);
    assign writeOk = progWrite && icpSync_reg && isOption(progAddr)
                     && !(wrIdx == `OBCD_IDX_RSVD && progWrData != `OBCD_RSVD_VAL);

    // non-volatile row: survives reset, factory value at power-up only
    always_ff @(posedge mclk) begin
        if (writeOk) begin
            optStore[wrIdx] <= progWrData;
        end
    end

    // write answer, one cycle after the strobe
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            progAck    <= 1'b0;
            progReject <= 1'b0;
        end else begin
            progAck    <= writeOk;
            progReject <= progWrite && !writeOk;
        end
    end

    // readback of the stored row; unmapped reads give zero
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            progRdData <= `OBCD_RD_IDLE;
        end else if (progRead) begin
            progRdData <= isOption(progAddr) ? optStore[byteIndex(progAddr)] : `OBCD_RD_IDLE;
        end
    end

    // loader: copy once after release, then freeze until reset
    always_comb begin
        case (loadState_reg)
            LOAD_IDLE: loadState_next = LOAD_COPY;
            LOAD_COPY: loadState_next = LOAD_DONE;
            LOAD_DONE: loadState_next = LOAD_DONE;
            default:   loadState_next = LOAD_IDLE;
        endcase
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            loadState_reg <= LOAD_IDLE;
        end else begin
            loadState_reg <= loadState_next;
        end
    end

    // holding copy; later programming does not disturb it
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            ropHeld_reg  <= `OBCD_FACTORY_VAL;
            bootHeld_reg <= `OBCD_FACTORY_VAL;
            dataHeld_reg <= `OBCD_FACTORY_VAL;
            wdgHeld_reg  <= `OBCD_FACTORY_VAL;
        end else if (loadState_reg == LOAD_COPY) begin
            ropHeld_reg  <= optStore[`OBCD_IDX_ROP];
            bootHeld_reg <= optStore[`OBCD_IDX_BOOT];
            dataHeld_reg <= optStore[`OBCD_IDX_DATA];
            wdgHeld_reg  <= optStore[`OBCD_IDX_WDG];
        end
    end

    assign cfg.ropByte  = ropHeld_reg;
    assign cfg.bootByte = bootHeld_reg;
    assign cfg.dataByte = dataHeld_reg;
    assign cfg.wdgByte  = wdgHeld_reg;
    assign cfg.held     = (loadState_reg == LOAD_DONE);

    obcd_field_decoder u_decoder (
        .mclk  (mclk),
        .rst_n (rst_n),
        .cfg   (cfg)
    );

    // decoded flags come from decoder flops; plain bytes registered here
    assign readoutProtectEn = cfg.readoutProtect;
    assign bootAreaEnable   = cfg.bootEnable;
    assign bootVectorsOnly  = cfg.bootVectorsOnly;
    assign bootWriteProtect = cfg.bootWriteProtect;
    assign bootAreaPages    = cfg.bootPages;

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            configValid           <= 1'b0;
            dataAreaSize          <= `OBCD_FACTORY_VAL;
            watchdogHaltOption    <= 1'b0;
            watchdogHwStartOption <= 1'b0;
        end else begin
            configValid           <= cfg.held; // one cycle after copy, aligned with decoder
            dataAreaSize          <= cfg.dataByte;
            watchdogHaltOption    <= cfg.wdgByte[`OBCD_WDG_HALT_BIT];
            watchdogHwStartOption <= cfg.wdgByte[`OBCD_WDG_HW_BIT];
        end
    end

    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);

    // programming path and held set
    a_write_needs_mode: assert property (progAck |-> $past(icpSync_reg) && $past(progWrite))
        else $error("option write taken outside programming mode");
    a_no_mode_reject: assert property (progWrite && !icpSync_reg |=> progReject && !progAck)
        else $error("write outside programming mode not refused");
    a_held_frozen: assert property (configValid |=> $stable(ropHeld_reg) && $stable(bootHeld_reg)
                                    && $stable(wdgHeld_reg))
        else $error("held option bytes changed before reset");
    a_valid_timing: assert property ($rose(cfg.held) |=> configValid
                                     && (readoutProtectEn == (ropHeld_reg == `OBCD_ROP_ENABLE)))
        else $error("configuration valid out of step");

    // answers are exclusive and never come without a strobe
    a_answer_onehot: assert property (!(progAck && progReject))
        else $error("write both accepted and refused");
    a_answer_cause: assert property (progAck || progReject |-> $past(progWrite))
        else $error("write answer without a strobe");

    // refusals for unmapped bytes and a nonzero reserved byte
    a_unmapped_refuse: assert property (progWrite && !isOption(progAddr) |=> progReject)
        else $error("unmapped option write not refused");
    a_rsvd_refuse: assert property (progWrite && progAddr == `OBCD_ADDR_RSVD
                                    && progWrData != `OBCD_RSVD_VAL |=> progReject && !progAck)
        else $error("nonzero reserved byte accepted");

    // an accepted byte lands in the row at its own index
    a_write_lands: assert property (writeOk |=> optStore[$past(wrIdx)] == $past(progWrData))
        else $error("accepted option byte not stored");
    a_read_unmapped: assert property (progRead && !isOption(progAddr) |=> progRdData == `OBCD_RD_IDLE)
        else $error("unmapped read not zero");

    // loader steps once through the copy and then stays put
    a_loader_once: assert property (loadState_reg == LOAD_COPY |=> loadState_reg == LOAD_DONE)
        else $error("loader did not finish the copy");
    c_prog_write: cover property (progAck);
    c_prog_reject: cover property (progReject);
    c_loaded: cover property (configValid && readoutProtectEn);
endmodule // obcd_config_decoder
`default_nettype wire

/* obcd_field_decoder.sv */
// Purpose: turns held option bytes into protection settings
// Assumes: inputs change only while the loader copies after reset
// Notes:   one cycle of latency from held bytes to decoded flags
`timescale 1ns/100ps
`default_nettype none
`include "obcd_opt_map.svh"
module obcd_field_decoder (
    // clock and reset
    input  wire logic     mclk,
    input  wire logic     rst_n,
    // held bytes in, decoded fields out
    obcd_cfg_if.decoder   cfg
);
    import obcd_pkg::*;

    logic [6:0] bootSize;

    // top bit never counts, whatever the stored byte holds
    assign bootSize = cfg.bootByte[`OBCD_BOOT_MSB-1:0];

    // decoded flags, refreshed every cycle from the held copy
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            cfg.readoutProtect   <= 1'b0;
            cfg.bootPages        <= 7'h00;
            cfg.bootVectorsOnly  <= 1'b0;
            cfg.bootEnable       <= 1'b0;
            cfg.bootWriteProtect <= 1'b0;
        end else begin
            cfg.readoutProtect   <= (cfg.ropByte == `OBCD_ROP_ENABLE);
            cfg.bootPages        <= bootSize;
            cfg.bootEnable       <= (bootSize != `OBCD_BOOT_NONE);
            cfg.bootVectorsOnly  <= (bootSize != `OBCD_BOOT_NONE) && (bootSize <= `OBCD_BOOT_VEC_MAX);
            cfg.bootWriteProtect <= (bootSize > `OBCD_BOOT_VEC_MAX);
        end
    end

    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);

    a_rop_decode: assert property ($past(cfg.ropByte) == `OBCD_ROP_ENABLE |-> cfg.readoutProtect)
        else $error("readout protection not enabled for enable value");
    a_rop_off: assert property ($past(cfg.ropByte) != `OBCD_ROP_ENABLE |-> !cfg.readoutProtect)
        else $error("readout protection on without enable value");
    a_boot_none: assert property ($past(cfg.bootByte[6:0]) == 7'h00 |-> !cfg.bootEnable && !cfg.bootWriteProtect)
        else $error("boot area present for size zero");
    a_boot_vectors: assert property ($past(cfg.bootByte[6:0]) inside {7'h01, 7'h02}
                                      |-> cfg.bootVectorsOnly && !cfg.bootWriteProtect)
        else $error("vector-only boot size decoded wrongly");
    a_boot_protect: assert property ($past(cfg.bootByte[6:0]) >= 7'h03 |-> cfg.bootWriteProtect && !cfg.bootVectorsOnly)
        else $error("boot area not write protected");
    a_boot_msb: assert property ($past(cfg.bootByte[6:0]) == cfg.bootPages)
        else $error("boot page count does not ignore top bit");
    c_boot_full: cover property (cfg.bootPages == 7'h7F && cfg.bootWriteProtect);
    c_rop_on: cover property (cfg.readoutProtect);
endmodule // obcd_field_decoder
`default_nettype wire

/* obcd_opt_map.svh */
// Purpose: option byte addresses, values and field positions
// Assumes: 16-bit debug-link address space, byte-wide option bytes
// Notes:   definitions only
`ifndef OBCD_OPT_MAP_SVH
`define OBCD_OPT_MAP_SVH

`define OBCD_ADDR_BASE      16'h4800
`define OBCD_ADDR_ROP       16'h4800
`define OBCD_ADDR_BOOT      16'h4802
`define OBCD_ADDR_DATA      16'h4803
`define OBCD_ADDR_RSVD      16'h4807
`define OBCD_ADDR_WDG       16'h4808
`define OBCD_IDX_ROP        4'h0
`define OBCD_IDX_BOOT       4'h2
`define OBCD_IDX_DATA       4'h3
`define OBCD_IDX_RSVD       4'h7
`define OBCD_IDX_WDG        4'h8
`define OBCD_NUM_BYTES      9
`define OBCD_FACTORY_VAL    8'h00
`define OBCD_RD_IDLE        8'h00
`define OBCD_RSVD_VAL       8'h00
`define OBCD_ROP_ENABLE     8'hAA
`define OBCD_BOOT_NONE      7'h00
`define OBCD_BOOT_VEC_MAX   7'h02
`define OBCD_BOOT_MSB       7
`define OBCD_WDG_HW_BIT     0
`define OBCD_WDG_HALT_BIT   1

`endif

/* obcd_pkg.sv */
// Purpose: shared types of the option byte decoder
// Assumes: nothing beyond the map header
// Notes:   loader walks idle, copy, done once per reset
package obcd_pkg;
    typedef logic [7:0]  obcd_byte_type;
    typedef logic [15:0] obcd_addr_type;
    typedef enum logic [1:0] {
        LOAD_IDLE = 2'b00,
        LOAD_COPY = 2'b01,
        LOAD_DONE = 2'b10
    } obcd_load_type;
endpackage

/* obcd_prog_model.sv */
// Purpose: in-circuit programmer model on the debug-link side
// Assumes: strobes change 2 ns after a rising mclk edge
// Notes:   address and data lines show the inverse of the last value when idle
`timescale 1ns/100ps
`default_nettype none
module obcd_prog_model (
    // clock
    input  wire logic                    mclk,
    // requests toward the device
    output var  logic                    icpModePin,
    output var  logic                    progWrite,
    output var  logic                    progRead,
    output var  obcd_pkg::obcd_addr_type progAddr,
    output var  obcd_pkg::obcd_byte_type progWrData,
    // answers from the device
    input  wire obcd_pkg::obcd_byte_type progRdData,
    input  wire logic                    progAck,
    input  wire logic                    progReject
);
    import obcd_pkg::*;

    // idle levels at time zero
    initial begin
        icpModePin = 1'b0;
        progWrite  = 1'b0;
        progRead   = 1'b0;
        progAddr   = 16'h0000;
        progWrData = 8'h00;
    end

    // option bytes change only with the mode pin up
    task automatic set_mode(input logic on);
        @(posedge mclk);
        #2 icpModePin = on;
    endtask

    // reserved byte gets nonzero data only when a scenario asks for it
    task automatic write_byte(input obcd_addr_type a, input obcd_byte_type d,
                              output logic ack, output logic rej);
        @(posedge mclk);
        #2;
        progWrite  = 1'b1;
        progAddr   = a;
        progWrData = d;
        @(posedge mclk);
        #2;
        ack        = progAck;
        rej        = progReject;
        progWrite  = 1'b0;
        progAddr   = ~a;
        progWrData = ~d;
    endtask

    // readback, answered one edge after the strobe
    task automatic read_byte(input obcd_addr_type a, output obcd_byte_type d);
        @(posedge mclk);
        #2;
        progRead = 1'b1;
        progAddr = a;
        @(posedge mclk);
        #2;
        d        = progRdData;
        progRead = 1'b0;
        progAddr = ~a;
    endtask
endmodule // obcd_prog_model
`default_nettype wire

/* option_byte_config_decoder_tb.sv */
// Purpose: self-checking bench for the option byte decoder
// Assumes: option store starts at 0x00
// Notes:   new option values are checked only after a following reset
`timescale 1ns/100ps
`default_nettype none
module option_byte_config_decoder_tb;
    import obcd_pkg::*;
    logic mclk, rst_n = 1'b0, icpModePin, progWrite, progRead, progAck, progReject, configValid;
    logic readoutProtectEn, bootAreaEnable, bootVectorsOnly, bootWriteProtect;
    logic watchdogHaltOption, watchdogHwStartOption;
    logic [6:0] bootAreaPages;
    obcd_addr_type progAddr;
    obcd_byte_type progWrData, progRdData, dataAreaSize;
    int n_fail = 0;
    int check_count = 0;

    obcd_config_decoder u_obcd_config_decoder (.mclk(mclk), .rst_n(rst_n), .icpModePin(icpModePin),
        .progWrite(progWrite), .progRead(progRead), .progAddr(progAddr), .progWrData(progWrData),
        .progRdData(progRdData), .progAck(progAck), .progReject(progReject), .configValid(configValid),
        .readoutProtectEn(readoutProtectEn), .bootAreaEnable(bootAreaEnable),
        .bootVectorsOnly(bootVectorsOnly), .bootWriteProtect(bootWriteProtect),
        .bootAreaPages(bootAreaPages), .dataAreaSize(dataAreaSize),
        .watchdogHaltOption(watchdogHaltOption), .watchdogHwStartOption(watchdogHwStartOption));
    obcd_prog_model u_obcd_prog_model (.mclk(mclk), .icpModePin(icpModePin), .progWrite(progWrite),
        .progRead(progRead), .progAddr(progAddr), .progWrData(progWrData), .progRdData(progRdData),
        .progAck(progAck), .progReject(progReject));

    // 20 MHz clock
    initial begin
        mclk = 1'b0;
        forever #25 mclk = ~mclk;
    end

    task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
        check_count++;
        if (got !== exp) begin
            n_fail++;
            $display("[FAIL] %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic test_done();
        $display("checks %0d mismatches %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask

    // reset for 8 cycles; decoded set is ready 3 edges after release
    task automatic do_reset();
        @(posedge mclk);
        #2 rst_n = 1'b0;
        repeat (8) @(posedge mclk);
        #2 rst_n = 1'b1;
        repeat (3) @(posedge mclk);
        #2 chk("configValid", 8'h01, {7'h00, configValid});
    endtask

    task automatic check_decoded(input obcd_byte_type readout_protect_value, boot, data, wdg);
        logic [6:0] p;
        p = boot[6:0];
        chk("readout", {7'h00, readout_protect_value == 8'hAA}, {7'h00, readoutProtectEn});
        chk("pages", {1'b0, p}, {1'b0, bootAreaPages});
        chk("bootFlags", {5'h00, p != 7'h00, p inside {7'h01, 7'h02}, p >= 7'h03},
            {5'h00, bootAreaEnable, bootVectorsOnly, bootWriteProtect});
        chk("data_area_size", data, dataAreaSize);
        chk("watchdog", {6'h00, wdg[1:0]}, {6'h00, watchdogHaltOption, watchdogHwStartOption});
    endtask

    task automatic wr(input obcd_addr_type a, input obcd_byte_type d, input logic okExp);
        logic ack, rej;
        u_obcd_prog_model.write_byte(a, d, ack, rej);
        chk("ackRej", {6'h00, okExp, ~okExp}, {6'h00, ack, rej});
    endtask

    // fresh store reads all zero, unmapped hole included
    task automatic test_defaults();
        obcd_byte_type d;
        obcd_addr_type addrTab [5] = '{16'h4800, 16'h4802, 16'h4803, 16'h4807, 16'h4808};
        check_decoded(8'h00, 8'h00, 8'h00, 8'h00);
        foreach (addrTab[i]) begin
            u_obcd_prog_model.read_byte(addrTab[i], d);
            chk("defaultByte", 8'h00, d);
        end
        u_obcd_prog_model.read_byte(16'h4801, d);
        chk("unmapped", 8'h00, d);
        u_obcd_prog_model.read_byte(16'h4808, d);
        chk("wdgReset", 8'h00, d);
        $display("test_defaults done");
    endtask

    // refusals leave the store and the held set untouched
    task automatic test_refusals();
        obcd_byte_type d;
        u_obcd_prog_model.set_mode(1'b0);
        repeat (3) @(posedge mclk);
        wr(16'h4800, 8'hAA, 1'b0);
        u_obcd_prog_model.set_mode(1'b1);
        repeat (3) @(posedge mclk);
        wr(16'h4805, 8'h11, 1'b0);
        wr(16'h4807, 8'h5A, 1'b0);
        wr(16'h4807, 8'h00, 1'b1);
        u_obcd_prog_model.read_byte(16'h4800, d);
        chk("ropStore", 8'h00, d);
        check_decoded(8'h00, 8'h00, 8'h00, 8'h00);
        $display("test_refusals done");
    endtask

    // program, confirm nothing moves, reset, then check the new decode
    task automatic test_decode();
        obcd_byte_type bootTab [7] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h40, 8'h7F, 8'hFF};
        obcd_byte_type pr, pb, pd, pw, r, d;
        {pr, pb, pd, pw} = 32'h0000_0000;
        foreach (bootTab[i]) begin
            r = (i % 2 == 1) ? 8'hAA : 8'h55;
            d = bootTab[i] ^ 8'h3C;
            wr(16'h4800, r, 1'b1);
            wr(16'h4802, bootTab[i], 1'b1);
            wr(16'h4803, d, 1'b1);
            wr(16'h4808, 8'(i), 1'b1);
            check_decoded(pr, pb, pd, pw);
            do_reset();
            check_decoded(r, bootTab[i], d, 8'(i));
            {pr, pb, pd, pw} = {r, bootTab[i], d, 8'(i)};
        end
        $display("test_decode done");
    endtask

    // hang guard at 20000 cycles, far beyond the fewer than 200 cycles the tests take
    initial begin
        #1000000;
        n_fail++;
        test_done();
    end

    initial begin
        do_reset();
        test_defaults();
        test_refusals();
        test_decode();
        test_done();
    end
endmodule // option_byte_config_decoder_tb
`default_nettype wire
